// File: design/adc_readout_cfg.svh
/*
 Constants of the converter readout block: widths, counts, reset values and timing.
 Assumes it is included by bare name, once per compilation unit or guarded.
*/
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH

`define RES_BITS 14
`define ACC_BITS 20
`define NUM_CH 8
`define SER_LAST_FALL 4'hD
`define SER_MSB_POS 4'hD
`define BYTE_LAST_IDX 4'hF
`define FLAG_BYTE_COUNT 4'h2
`define CH_B_OFFSET 3'h4
`define OS_INVALID 3'h7
`define OS_RESET 3'h0
`define PIN_WIDTH 11
`define PIN_RST 11'h700
`define CLK_PERIOD_NS 4
`define OS_GAP_NS 1000
`define OS_GAP_CYC ((`OS_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: design/adc_readout_pkg.sv
/*
 Types shared by the readout block: result words, channel sets, pin bundle, states.
 Assumes adc_readout_cfg.svh is on the include path.
*/
`include "adc_readout_cfg.svh"

package adc_readout_pkg;

    typedef logic signed [`RES_BITS-1:0] result_t;
    typedef result_t [`NUM_CH-1:0] chanSet_t;

    typedef struct packed {
        logic chipSelN;
        logic readN;
        logic serialClk;
        logic convStartA;
        logic convStartB;
        logic ifaceSel;
        logic byteSel;
        logic upperFirst;
        logic [2:0] osSel;
    } pinIn_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_GAP  = 3'h4
    } convState_t;

endpackage : adc_readout_pkg

// File: design/pin_sync.sv
/*
 Three-flop synchroniser for a vector of pins; a bit changes once stages two and three agree.
 Assumes pins are asynchronous to clk; reset value chosen per bit to match idle pin levels.
*/
`timescale 1ns/10ps
`default_nettype none

module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins and clean levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] nxt_out;

    // stage one feeds stage two only
    always_comb begin
        nxt_out = (~(stage2_ff ^ stage3_ff) & stage3_ff) | ((stage2_ff ^ stage3_ff) & out_ff);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_ff <= RST_VAL;
            stage2_ff <= RST_VAL;
            stage3_ff <= RST_VAL;
            out_ff <= RST_VAL;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            out_ff <= nxt_out;
        end
    end

    assign syncOut = out_ff;

endmodule : pin_sync

`default_nettype wire

// File: design/sinc_averager.sv
/*
 First-order sinc filter: per-channel accumulate, mean rounded by a power-of-two shift.
 Assumes clear and add never coincide; means include the sample presented with add.
*/
`timescale 1ns/10ps
`default_nettype none

module sinc_averager import adc_readout_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // control
    input wire logic clear,
    input wire logic add,
    input wire logic [2:0] shift,
    // samples in, means out
    input wire chanSet_t samples,
    output chanSet_t means
);

    logic [`NUM_CH-1:0][`ACC_BITS-1:0] acc_ff;
    logic [`NUM_CH-1:0][`ACC_BITS-1:0] nxt_acc;
    logic [`NUM_CH-1:0][`ACC_BITS-1:0] sumV;
    logic [`ACC_BITS-1:0] rndV;

    always_comb begin
        // half an output step, so the shift rounds to nearest instead of truncating
        rndV = (shift == 3'h0) ? '0 : `ACC_BITS'(`ACC_BITS'h1 << (shift - 3'h1)); // RULE24
        for (int i = 0; i < `NUM_CH; i++) begin
            sumV[i] = `ACC_BITS'($signed(acc_ff[i]) + $signed(samples[i])); // RULE19
            nxt_acc[i] = clear ? '0 : (add ? sumV[i] : acc_ff[i]);
            means[i] = `RES_BITS'($signed(`ACC_BITS'(sumV[i] + rndV)) >>> shift); // RULE24
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

endmodule : sinc_averager

`default_nettype wire

// File: design/adc_readout_core.sv
/*
 Readout and oversampling control of an eight-channel 14-bit simultaneous converter:
 conversion sequencing with sinc averaging, byte-wide parallel reads, dual-line serial reads.
 Assumes the converter core answers each sample strobe with coreValid and eight results,
 and that the host serial clock idles high between frames.
*/
// Behaviour
// RULE1: byte mode gives each result as two bytes, sixteen reads for eight channels
// RULE2: byte mode needs interface select and byte select both high
// RULE3: bytes leave on the low eight data lines, bit 0 least significant
// RULE4: byte order input high gives upper byte first, low gives lower byte first
// RULE5: two top bits of the upper byte copy the result sign bit
// RULE6: byte mode first-channel flag stays high until both channel one bytes are read
// RULE7: serial line A starts at channel one, line B at channel five
// RULE8: chip select fall enables serial lines with the MSB; clock rises shift on
// RULE9: fourteen serial clocks per result, host samples on falling edges
// RULE10: chip select may frame the whole read or each fourteen-clock word
// RULE11: full read takes 56 clocks on both lines or 112 on one
// RULE12: line B alone gives channels five to eight then one to four
// RULE13: serial flag floats with chip select high, drops after fourteenth falling edge
// RULE14: flag is not raised when channel one leaves on line B
// RULE15: reads of previous results are allowed while busy is high
// RULE16: result registers update at busy fall; host avoids reading then
// RULE17: oversampling select latched at busy fall, used for the next conversion
// RULE18: select codes 000 to 110 give ratios 1 to 64; 111 is not allowed
// RULE19: nonzero ratio passes samples through a first-order sinc filter
// RULE20: first sample at conversion start, the rest from an internal strobe
// RULE21: both conversion starts driven together while oversampling
// RULE22: busy rises at conversion start, falls when all samples are done
// RULE23: each read after busy falls advances one channel, starting at channel one
// RULE24: filter output is the rounded mean of the selected sample count
`timescale 1ns/10ps
`default_nettype none

module adc_readout_core import adc_readout_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // host control pins
    input wire logic chipSelectN,
    input wire logic readN,
    input wire logic serialClk,
    input wire logic conversionStartA,
    input wire logic conversionStartB,
    // static configuration pins
    input wire logic interfaceSelect,
    input wire logic byteModeSelect,
    input wire logic upperByteFirst,
    input wire logic [2:0] oversampleRatioSel,
    // converter core
    input wire logic coreValid,
    input wire chanSet_t coreSamples,
    output logic coreSampleStrobe,
    // conversion status
    output logic busy,
    // byte data bus
    output logic [7:0] dataOut,
    output logic dataOe,
    // serial lines
    output logic serialOutA,
    output logic serialOutAOe,
    output logic serialOutB,
    output logic serialOutBOe,
    // first-channel indicator
    output logic firstChannelFlag,
    output logic firstChannelFlagOe
);

    localparam int GAP_CYC = `OS_GAP_CYC;
    localparam int STROBE_LAG = GAP_CYC + 1;

    // pin synchronisation and edges
    pinIn_t pinRaw;
    pinIn_t pins;
    logic [`PIN_WIDTH-1:0] pinsVec;
    pinIn_t pinsPrev_ff;
    logic csFall;
    logic rdFall;
    logic sclkRise;
    logic sclkFall;
    logic convARise;
    logic convBRise;
    logic byteMode;
    logic serialMode;

    assign pinRaw = '{chipSelN: chipSelectN, readN: readN, serialClk: serialClk,
                      convStartA: conversionStartA, convStartB: conversionStartB,
                      ifaceSel: interfaceSelect, byteSel: byteModeSelect,
                      upperFirst: upperByteFirst, osSel: oversampleRatioSel};

    pin_sync #(
        .WIDTH(`PIN_WIDTH),
        .RST_VAL(`PIN_RST)
    ) u_pin_sync (
        .clk(clk),
        .rst(rst),
        .asyncIn(pinRaw),
        .syncOut(pinsVec)
    );

    assign pins = pinIn_t'(pinsVec);
    assign csFall = pinsPrev_ff.chipSelN & ~pins.chipSelN;
    assign rdFall = pinsPrev_ff.readN & ~pins.readN;
    assign sclkRise = ~pinsPrev_ff.serialClk & pins.serialClk;
    assign sclkFall = pinsPrev_ff.serialClk & ~pins.serialClk;
    assign convARise = ~pinsPrev_ff.convStartA & pins.convStartA;
    assign convBRise = ~pinsPrev_ff.convStartB & pins.convStartB;
    assign byteMode = pins.ifaceSel & pins.byteSel; // RULE2
    assign serialMode = pins.ifaceSel & ~pins.byteSel;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinsPrev_ff <= pinIn_t'(`PIN_RST);
        end else begin
            pinsPrev_ff <= pins;
        end
    end

    // conversion sequencing
    convState_t state_ff;
    convState_t nxt_state;
    logic armA_ff;
    logic nxt_armA;
    logic armB_ff;
    logic nxt_armB;
    logic [6:0] sampCnt_ff;
    logic [6:0] nxt_sampCnt;
    logic [8:0] gapCnt_ff;
    logic [8:0] nxt_gapCnt;
    logic busy_ff;
    logic nxt_busy;
    logic strobe_ff;
    logic nxt_strobe;
    logic [2:0] osCode_ff;
    logic [2:0] nxt_osCode;
    logic [2:0] osShift;
    logic [6:0] ratio;
    logic lastSample;
    logic startEv;
    logic busyFallEv;

    // an illegal code falls back to no averaging rather than an undefined ratio
    assign osShift = (osCode_ff == `OS_INVALID) ? 3'h0 : osCode_ff; // RULE18
    assign ratio = 7'(7'h1 << osShift); // RULE18
    assign lastSample = (7'(sampCnt_ff + 7'h1) == ratio);

    always_comb begin
        nxt_state = state_ff;
        nxt_armA = armA_ff;
        nxt_armB = armB_ff;
        nxt_sampCnt = sampCnt_ff;
        nxt_gapCnt = gapCnt_ff;
        nxt_busy = busy_ff;
        nxt_strobe = 1'b0;
        nxt_osCode = osCode_ff;
        startEv = 1'b0;
        busyFallEv = 1'b0;
        unique case (state_ff)
            ST_IDLE: begin
                // conversion begins on the later of the two start edges
                startEv = (armA_ff | convARise) & (armB_ff | convBRise); // RULE21
                nxt_armA = armA_ff | convARise;
                nxt_armB = armB_ff | convBRise;
                if (startEv) begin
                    nxt_armA = 1'b0;
                    nxt_armB = 1'b0;
                    nxt_busy = 1'b1; // RULE22
                    nxt_strobe = 1'b1; // RULE20
                    nxt_sampCnt = 7'h0;
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (coreValid) begin
                    nxt_sampCnt = 7'(sampCnt_ff + 7'h1);
                    if (lastSample) begin
                        busyFallEv = 1'b1;
                        nxt_busy = 1'b0; // RULE22
                        nxt_osCode = pins.osSel; // RULE17
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_gapCnt = 9'(GAP_CYC - 1);
                        nxt_state = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                if (gapCnt_ff == 9'h0) begin
                    nxt_strobe = 1'b1; // RULE20
                    nxt_state = ST_WAIT;
                end else begin
                    nxt_gapCnt = 9'(gapCnt_ff - 9'h1);
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            armA_ff <= 1'b0;
            armB_ff <= 1'b0;
            sampCnt_ff <= 7'h0;
            gapCnt_ff <= 9'h0;
            busy_ff <= 1'b0;
            strobe_ff <= 1'b0;
            osCode_ff <= `OS_RESET;
        end else begin
            state_ff <= nxt_state;
            armA_ff <= nxt_armA;
            armB_ff <= nxt_armB;
            sampCnt_ff <= nxt_sampCnt;
            gapCnt_ff <= nxt_gapCnt;
            busy_ff <= nxt_busy;
            strobe_ff <= nxt_strobe;
            osCode_ff <= nxt_osCode;
        end
    end

    // averaging and output result registers
    chanSet_t avgMeans;
    chanSet_t results_ff;
    chanSet_t nxt_results;

    sinc_averager u_sinc_averager (
        .clk(clk),
        .rst(rst),
        .clear(startEv),
        .add(coreValid & (state_ff == ST_WAIT)),
        .shift(osShift),
        .samples(coreSamples),
        .means(avgMeans)
    );

    always_comb begin
        nxt_results = busyFallEv ? avgMeans : results_ff; // RULE16
    end

    // reads, byte and serial
    logic [3:0] byteIdx_ff;
    logic [3:0] nxt_byteIdx;
    logic [7:0] dataOut_ff;
    logic [7:0] nxt_dataOut;
    logic dataOe_ff;
    logic nxt_dataOe;
    logic [2:0] wordIdx_ff;
    logic [2:0] nxt_wordIdx;
    logic [3:0] bitPos_ff;
    logic [3:0] nxt_bitPos;
    logic [3:0] fallCnt_ff;
    logic [3:0] nxt_fallCnt;
    logic boundary_ff;
    logic nxt_boundary;
    logic serA_ff;
    logic nxt_serA;
    logic serB_ff;
    logic nxt_serB;
    logic serOe_ff;
    logic nxt_serOe;
    logic flag_ff;
    logic nxt_flag;
    logic flagOe_ff;
    logic nxt_flagOe;
    result_t byteRes;
    logic [7:0] upperByte;
    logic [7:0] lowerByte;
    logic wantUpper;
    logic byteFlag;

    assign byteRes = results_ff[byteIdx_ff[3:1]]; // RULE1
    assign upperByte = {byteRes[13], byteRes[13], byteRes[13:8]}; // RULE5
    assign lowerByte = byteRes[7:0];
    assign wantUpper = pins.upperFirst ^ byteIdx_ff[0]; // RULE4
    // the third read's fall still sees index two, so it must not re-raise the flag
    assign byteFlag = (byteIdx_ff < `FLAG_BYTE_COUNT)
                      | ((byteIdx_ff == `FLAG_BYTE_COUNT) & ~pins.readN & ~rdFall); // RULE6

    // reads are never gated by busy; only the busy fall itself reloads the pointers
    always_comb begin
        nxt_byteIdx = byteIdx_ff;
        nxt_dataOut = dataOut_ff;
        nxt_wordIdx = wordIdx_ff;
        nxt_bitPos = bitPos_ff;
        nxt_fallCnt = fallCnt_ff;
        nxt_boundary = boundary_ff;
        if (byteMode && rdFall) begin
            nxt_dataOut = wantUpper ? upperByte : lowerByte; // RULE15
            nxt_byteIdx = 4'(byteIdx_ff + 4'h1); // RULE23
        end
        if (serialMode && csFall) begin
            nxt_bitPos = `SER_MSB_POS; // RULE8
            nxt_fallCnt = 4'h0;
            nxt_boundary = 1'b0;
        end else if (serialMode && !pins.chipSelN) begin
            if (sclkFall) begin
                if (fallCnt_ff == `SER_LAST_FALL) begin
                    nxt_fallCnt = 4'h0; // RULE9
                    nxt_wordIdx = 3'(wordIdx_ff + 3'h1);
                    nxt_boundary = 1'b1;
                end else begin
                    nxt_fallCnt = 4'(fallCnt_ff + 4'h1);
                end
            end
            if (sclkRise) begin
                if (boundary_ff) begin
                    nxt_bitPos = `SER_MSB_POS;
                    nxt_boundary = 1'b0;
                end else if (bitPos_ff != 4'h0) begin
                    nxt_bitPos = 4'(bitPos_ff - 4'h1); // RULE8
                end
            end
        end
        if (busyFallEv) begin
            nxt_byteIdx = 4'h0; // RULE23
            nxt_wordIdx = 3'h0; // RULE23
        end
        nxt_dataOe = byteMode & ~pins.chipSelN & ~pins.readN; // RULE3
        nxt_serA = results_ff[nxt_wordIdx][nxt_bitPos]; // RULE7
        nxt_serB = results_ff[3'(nxt_wordIdx + `CH_B_OFFSET)][nxt_bitPos]; // RULE12
        nxt_serOe = serialMode & ~pins.chipSelN; // RULE8
        // the flag tracks line A, so channel one on line B never raises it
        nxt_flag = byteMode ? byteFlag : (nxt_wordIdx == 3'h0); // RULE14
        nxt_flagOe = byteMode | (serialMode & ~pins.chipSelN); // RULE13
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            results_ff <= '0;
            byteIdx_ff <= 4'h0;
            dataOut_ff <= 8'h00;
            dataOe_ff <= 1'b0;
            wordIdx_ff <= 3'h0;
            bitPos_ff <= `SER_MSB_POS;
            fallCnt_ff <= 4'h0;
            boundary_ff <= 1'b0;
            serA_ff <= 1'b0;
            serB_ff <= 1'b0;
            serOe_ff <= 1'b0;
            flag_ff <= 1'b0;
            flagOe_ff <= 1'b0;
        end else begin
            results_ff <= nxt_results;
            byteIdx_ff <= nxt_byteIdx;
            dataOut_ff <= nxt_dataOut;
            dataOe_ff <= nxt_dataOe;
            wordIdx_ff <= nxt_wordIdx;
            bitPos_ff <= nxt_bitPos;
            fallCnt_ff <= nxt_fallCnt;
            boundary_ff <= nxt_boundary;
            serA_ff <= nxt_serA;
            serB_ff <= nxt_serB;
            serOe_ff <= nxt_serOe;
            flag_ff <= nxt_flag;
            flagOe_ff <= nxt_flagOe;
        end
    end

    assign coreSampleStrobe = strobe_ff;
    assign busy = busy_ff;
    assign dataOut = dataOut_ff;
    assign dataOe = dataOe_ff;
    assign serialOutA = serA_ff;
    assign serialOutAOe = serOe_ff;
    assign serialOutB = serB_ff;
    assign serialOutBOe = serOe_ff;
    assign firstChannelFlag = flag_ff;
    assign firstChannelFlagOe = flagOe_ff;

    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence serialFrameStart;
        serialMode && csFall;
    endsequence

    sequence lastWordFall;
        serialMode && !pins.chipSelN && sclkFall && fallCnt_ff == `SER_LAST_FALL
            && wordIdx_ff == 3'h0;
    endsequence

    start_raises_busy_a: assert property (startEv |=> busy && coreSampleStrobe) // RULE22
        else $error("busy or first strobe missing after conversion start");
    internal_strobe_a: assert property ((state_ff == ST_WAIT && coreValid && !lastSample)
        |-> ##STROBE_LAG coreSampleStrobe) // RULE20
        else $error("internal sample strobe not at the expected gap");
    results_at_fall_a: assert property ($changed(results_ff) |-> $past(busyFallEv) && !busy) // RULE16
        else $error("results changed away from busy fall");
    ratio_latch_a: assert property ($fell(busy) |-> osCode_ff == $past(pins.osSel)) // RULE17
        else $error("oversampling select not latched at busy fall");
    sign_copy_a: assert property ($past(rdFall && byteMode && wantUpper)
        |-> dataOut[7] == dataOut[5] && dataOut[6] == dataOut[5]) // RULE5
        else $error("upper byte top bits do not copy the sign");
    byte_order_a: assert property ((rdFall && byteMode && !byteIdx_ff[0])
        |=> dataOut == ($past(pins.upperFirst) ? $past(upperByte) : $past(lowerByte))) // RULE4
        else $error("first byte of a result has the wrong order");
    byte_wrap_a: assert property ((rdFall && byteMode && byteIdx_ff == `BYTE_LAST_IDX
        && !busyFallEv) |=> byteIdx_ff == 4'h0) // RULE1
        else $error("sixteen byte reads do not cover all channels");
    byte_flag_a: assert property ((byteMode && byteIdx_ff < `FLAG_BYTE_COUNT)
        |=> firstChannelFlag && firstChannelFlagOe) // RULE6
        else $error("first-channel flag low before channel one is read");
    byte_flag_drop_a: assert property ((byteMode && rdFall && byteIdx_ff == `FLAG_BYTE_COUNT)
        |=> !firstChannelFlag) // RULE6
        else $error("first-channel flag high on the third byte read");
    serial_msb_a: assert property (serialFrameStart |=> serialOutAOe && serialOutBOe
        && serialOutA == $past(results_ff[wordIdx_ff][13])) // RULE8
        else $error("serial frame does not start with the MSB");
    flag_drop_a: assert property (lastWordFall |=> !firstChannelFlag) // RULE13
        else $error("first-channel flag not dropped after fourteenth fall");
    read_restart_a: assert property (busyFallEv |=> byteIdx_ff == 4'h0 && wordIdx_ff == 3'h0) // RULE23
        else $error("read pointers not restarted at busy fall");
    byte_bus_oe_a: assert property (dataOe |-> $past(byteMode)) // RULE3
        else $error("byte bus driven outside byte mode");

endmodule : adc_readout_core

`default_nettype wire

// File: tb/adc_core_model.sv
/*
 Behavioural converter core: answers each sample strobe with one valid pulse and eight results.
 Assumes the bench holds the pattern steady for a whole conversion.
*/
`timescale 1ns/10ps
`default_nettype none

module adc_core_model import adc_readout_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request and pacing
    input wire logic strobe,
    input wire logic slow,
    input wire chanSet_t pattern,
    // answer
    output logic valid = 1'b0,
    output chanSet_t samples = '0
);
    logic odd = 1'b0;
    int waitN = 0;

    // samples toggle outside valid so a late capture in the block shows up as a mismatch
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            valid <= 1'b0;
            waitN <= 0;
        end else if (strobe) begin
            valid <= 1'b0;
            waitN <= slow ? 40 : 1;
        end else begin
            valid <= (waitN == 1);
            odd <= odd ^ (waitN == 1);
            waitN <= (waitN > 0) ? waitN - 1 : 0;
        end
        // every second answer has bit 0 flipped, so an even-count mean lands on a half step
        samples <= (!rst && !strobe && waitN == 1) ? (pattern ^ {8{13'h0, odd}}) : ~samples;
    end
endmodule : adc_core_model
`default_nettype wire

// File: tb/adc_result_readout_oversampling_tb.sv
/*
 Self-checking bench for the readout block: byte reads, dual-line serial reads, oversampling.
 Assumes the core model in adc_core_model.sv and the design package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module adc_result_readout_oversampling_tb import adc_readout_pkg::*; ;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic slow = 1'b0;
    logic oeLast = 1'b0;
    pinIn_t p = 11'h700;
    chanSet_t pat = '0;
    chanSet_t res = '0;
    chanSet_t coreSamples;
    logic coreSampleStrobe, coreValid, busy, dataOe, serialOutA, serialOutAOe;
    logic serialOutB, serialOutBOe, firstChannelFlag, firstChannelFlagOe;
    logic [7:0] dataOut;
    logic [13:0] wa, wb;
    logic [1:0] fl;
    logic [29:0] q[$];
    logic [31:0] rnd = 32'h8EB7;
    int nb = 0;
    int err_count = 0;
    int samples_checked = 0;

    always #2 clk = ~clk;

    adc_readout_core dut (.clk, .rst, .chipSelectN(p.chipSelN), .readN(p.readN),
        .serialClk(p.serialClk), .conversionStartA(p.convStartA),
        .conversionStartB(p.convStartB), .interfaceSelect(p.ifaceSel),
        .byteModeSelect(p.byteSel), .upperByteFirst(p.upperFirst),
        .oversampleRatioSel(p.osSel), .coreValid, .coreSamples, .coreSampleStrobe, .busy,
        .dataOut, .dataOe, .serialOutA, .serialOutAOe, .serialOutB, .serialOutBOe,
        .firstChannelFlag, .firstChannelFlagOe);

    adc_core_model core (.clk, .rst, .strobe(coreSampleStrobe), .slow, .pattern(pat),
        .valid(coreValid), .samples(coreSamples));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = x[0] ? ((x >> 1) ^ 32'h80200003) : (x >> 1);
    endfunction : lfsr

    task automatic close_out();
        if (err_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    task automatic check(input logic [29:0] e, input logic [29:0] got);
        samples_checked++;
        if (e !== got) begin
            err_count++;
            $display("Error at %0t: expected %h got %h", $time, e, got);
        end
    endtask : check

    task automatic checkByte(input logic [29:0] e, input logic [29:0] got);
        check(e, got);
    endtask : checkByte

    task automatic checkWord(input logic [29:0] e, input logic [29:0] got);
        check(e, got);
    endtask : checkWord

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic newPat();
        for (int c = 0; c < 8; c++) begin
            rnd = lfsr(rnd);
            pat[c] <= rnd[13:0];
        end
    endtask : newPat

    task automatic convert(input logic [2:0] os);
        @(posedge clk);
        p.osSel <= os;
        p.convStartA <= 1'b1;
        p.convStartB <= 1'b1;
        tick(10);
        p.convStartA <= 1'b0;
        p.convStartB <= 1'b0;
    endtask : convert

    // with averaging, half the samples differ by one, and round-to-nearest gives bit 0 set
    task automatic waitIdle(input logic avg);
        for (int n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge clk);
        check(30'h0, busy);
        for (int c = 0; c < 8; c++)
            res[c] = avg ? (pat[c] | 14'h1) : pat[c];
        tick(10);
    endtask : waitIdle

    task automatic readBytes(input logic up);
        logic [7:0] b;
        int c;
        @(posedge clk);
        p.upperFirst <= up;
        tick(10);
        for (int i = 0; i < 16; i++) begin
            c = i / 2;
            b = (i[0] == up) ? res[c][7:0] : {res[c][13], res[c][13], res[c][13:8]};
            q.push_back({20'h0, 1'b1, i < 2, b});
            p.readN <= 1'b0;
            tick(10);
            p.readN <= 1'b1;
            tick(10);
        end
    endtask : readBytes

    // one frame of n whole words; the word index carries over between frames
    task automatic serialWords(input int first, input int n);
        @(posedge clk);
        p.chipSelN <= 1'b0;
        for (int w = first; w < first + n; w++) begin
            q.push_back({1'b1, w == 0, res[w % 8], res[(w + 4) % 8]});
            repeat (14) begin
                tick(20);
                p.serialClk <= 1'b0;
                tick(20);
                p.serialClk <= 1'b1;
            end
        end
        tick(20);
        p.chipSelN <= 1'b1;
        tick(20);
        check(30'h0, {firstChannelFlagOe, serialOutAOe, serialOutBOe});
    endtask : serialWords

    always @(negedge clk) begin
        if (dataOe === 1'b1 && oeLast !== 1'b1)
            checkByte(q.pop_front(), {20'h0, firstChannelFlagOe, firstChannelFlag, dataOut});
        oeLast = dataOe;
    end

    // host samples on falling serial clock edges
    always @(negedge p.serialClk) begin
        if (nb == 0)
            fl = {firstChannelFlagOe, firstChannelFlag};
        wa = {wa[12:0], serialOutA};
        wb = {wb[12:0], serialOutB};
        nb++;
        if (nb == 14) begin
            checkWord(q.pop_front(), {fl, wa, wb});
            nb = 0;
        end
    end

    initial begin
        #100000;
        err_count++;
        close_out();
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        p.ifaceSel <= 1'b1;
        p.byteSel <= 1'b1;
        tick(4);
        newPat();
        slow <= 1'b1;
        convert(3'h3);
        check(30'h1, busy);
        waitIdle(1'b0);
        p.chipSelN <= 1'b0;
        tick(10);
        readBytes(1'b1);
        newPat();
        slow <= 1'b0;
        convert(3'h0);
        readBytes(1'b0);
        check(30'h1, busy);
        tick(1000);
        check(30'h1, busy);
        waitIdle(1'b1);
        p.byteSel <= 1'b0;
        p.chipSelN <= 1'b1;
        tick(10);
        serialWords(0, 2);
        serialWords(2, 1);
        serialWords(3, 1);
        serialWords(4, 4);
        close_out();
    end
endmodule : adc_result_readout_oversampling_tb
`default_nettype wire
